// [hw/tcw_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tcw_timer import tcw_pkg::*; #(
	parameter bit TYPE0 = 1'b1,
	parameter int NUM_CC = 4
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [ADR_W-1:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [NCH-1:0] I_EVENT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	output logic [PORT_W-1:0] O_PORT,
	output logic O_OVF_EV,
	output logic O_ERR_EV,
	output logic O_HUNF_EV,
	output logic [NCH-1:0] O_CC_EV,
	output logic O_FAULT
);
	tcw_state_type s;
	tcw_state_type next_s;

	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		tcw_ctrl_type c;
		logic [NCH-1:0] ev;
		logic [NCH-1:0] rise;
		logic [NCH-1:0] lvl;
		logic [NCH-1:0] crise;
		logic [NCH-1:0] cfall;
		logic [7:0] flg;
		logic [31:0] wd;
		logic [31:0] rd;
		logic [15:0] top;
		logic [16:0] thr;
		logic [7:0] cadr;
		logic [7:0] wgp;
		logic [1:0] ch;
		logic tick;
		logic down;
		logic qdn;
		logic upd;
		logic capt;
		logic dbit;
		logic any_dt;
		logic awon;
		logic bus;
		c = s.ctrl;
		next_s = s;
		flg = '0;
		rd = '0;
		wd = '0;
		upd = 1'b0;
		any_dt = 1'b0;
		top = 16'h0000;
		thr = 17'h00000;
		cadr = 8'h00;
		wgp = 8'h00;
		ch = 2'h0;
		tick = 1'b0;
		down = 1'b0;
		qdn = 1'b0;
		capt = 1'b0;
		dbit = 1'b0;
		awon = 1'b0;
		ev = s.sync2;
		rise = ev & ~s.evd;
		lvl = c.nc_en ? s.evf : ev;
		crise = lvl & ~s.capl;
		cfall = ~lvl & s.capl;
		next_s.sync1 = I_EVENT;
		next_s.sync2 = s.sync1;
		next_s.evd = ev;
		next_s.capl = lvl;
		next_s.qprev = ev[1:0];
		next_s.pre = s.pre + 8'h01;
		next_s.ev_ovf = 1'b0;
		next_s.ev_err = 1'b0;
		next_s.ev_hunf = 1'b0;
		next_s.ev_cc = '0;
		bus = I_WB_CYC && I_WB_STB && !s.ack;
		next_s.ack = bus;

		// glitch filter: a level must hold four samples before capture logic sees it
		for (int i = 0; i < NCH; i++) begin
			if (ev[i] == s.evf[i]) begin
				next_s.nc[i] = '0;
			end else if (s.nc[i] == NC_LAST) begin
				next_s.evf[i] = ev[i];
				next_s.nc[i] = '0;
			end else begin
				next_s.nc[i] = s.nc[i] + 2'h1;
			end
		end

		// dead-time units; halting the count stretches the period but keeps duty exact
		for (int i = 0; i < NCH; i++) begin
			next_s.wgd[i] = s.wg[i];
			if (!s.awx.dti_en[i]) begin
				next_s.ls[i] = s.wg[i];
				next_s.hs[i] = ~s.wg[i];
				next_s.dtc[i] = '0;
			end else if (s.wg[i] != s.wgd[i]) begin
				next_s.ls[i] = 1'b0;
				next_s.hs[i] = 1'b0;
				next_s.dtc[i] = s.wg[i] ? s.dt.ls : s.dt.hs;
			end else if (s.dtc[i] != 8'h00) begin
				next_s.dtc[i] = s.dtc[i] - 8'h01;
				any_dt = 1'b1;
			end else begin
				next_s.ls[i] = s.wg[i];
				next_s.hs[i] = ~s.wg[i];
			end
		end

		qdn = ~(s.qprev[0] ^ ev[1]);
		unique case (c.clksel)
			CK_OFF: tick = 1'b0;
			CK_EV: tick = c.qdec ? (ev[1:0] != s.qprev) : rise[c.clk_ch];
			default: tick = (s.pre & DIV_MASK[c.clksel]) == DIV_MASK[c.clksel];
		endcase
		if (s.awx.halt_dt && any_dt) begin
			tick = 1'b0;
		end
		down = c.split | (c.qdec ? qdn : (c.dir_ev ? ev[c.dir_ch] : c.down));
		top = (c.wgm == WG_FREQ && !c.cap_mode) ? s.cc[0] : s.per;

		if (c.split) begin
			if (tick) begin
				if (s.cnt[7:0] == 8'h00) begin
					next_s.cnt[7:0] = s.per[7:0];
					upd = 1'b1;
				end else begin
					next_s.cnt[7:0] = s.cnt[7:0] - 8'h01;
				end
				if (s.cnt[15:8] == 8'h00) begin
					next_s.cnt[15:8] = s.per[15:8];
					flg[S_HUNF] = 1'b1;
				end else begin
					next_s.cnt[15:8] = s.cnt[15:8] - 8'h01;
				end
			end
		end else if (tick) begin
			if (c.wgm == WG_DUAL && !c.cap_mode) begin
				if (!s.dual_dn) begin
					if (s.cnt >= top) begin
						next_s.dual_dn = 1'b1;
						next_s.cnt = s.cnt - 16'h0001;
					end else begin
						next_s.cnt = s.cnt + 16'h0001;
					end
				end else if (s.cnt == 16'h0000) begin
					next_s.dual_dn = 1'b0;
					next_s.cnt = 16'h0001;
					upd = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 16'h0001;
				end
			end else if (down) begin
				if (s.cnt == 16'h0000) begin
					next_s.cnt = top;
					upd = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 16'h0001;
				end
			end else if (s.cnt >= top) begin
				next_s.cnt = 16'h0000;
				upd = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 16'h0001;
			end
		end
		if (c.rst_en && rise[c.rst_ch]) begin
			next_s.cnt = c.split ? s.per : (down ? top : 16'h0000);
			next_s.dual_dn = 1'b0;
		end
		if (upd) begin
			flg[S_OVF] = 1'b1;
			next_s.ftog = ~s.ftog;
			next_s.phase = s.phase + 3'h1;
		end
		if (upd || c.clksel == CK_OFF) begin
			next_s.per = s.per_buf;
			next_s.dt = s.dt_buf;
			next_s.ovr.pat = s.pat_buf;
			if (!c.cap_mode) begin
				next_s.cc = s.cc_buf;
			end
		end

		for (int i = 0; i < NCH; i++) begin
			next_s.wg[i] = 1'b0;
			next_s.wgh[i] = 1'b0;
			if (i < NUM_CC && c.cc_en[i]) begin
				if (!c.cap_mode) begin
					if (c.split) begin
						next_s.wg[i] = s.cnt[7:0] < s.cc[i][7:0];
						next_s.wgh[i] = s.cnt[15:8] < s.cc[i][15:8];
						if (tick && s.cnt[7:0] == s.cc[i][7:0]) begin
							flg[S_CC + i] = 1'b1;
						end
					end else begin
						unique case (c.hires)
							HR_X4: dbit = s.phase[1:0] < s.hrf[i][1:0];
							HR_X8: dbit = s.phase < s.hrf[i];
							HR_OFF, HR_RSVD: dbit = 1'b0;
						endcase
						thr = {1'b0, s.cc[i]} + {16'h0000, dbit};
						unique case (c.wgm)
							WG_SINGLE, WG_DUAL: next_s.wg[i] = {1'b0, s.cnt} < thr;
							WG_FREQ: next_s.wg[i] = (i == 0) ? s.ftog : 1'b0;
							WG_NORMAL: next_s.wg[i] = 1'b0;
						endcase
						if (tick && s.cnt == s.cc[i]) begin
							flg[S_CC + i] = 1'b1;
						end
					end
				end else begin
					ch = c.cap_ch + 2'(i);
					capt = 1'b0;
					unique case (c.cap_kind)
						CAP_INPUT: capt = crise[ch];
						CAP_FREQ: begin
							capt = crise[ch];
							if (crise[ch]) begin
								next_s.cnt = 16'h0000;
							end
						end
						CAP_PW: begin
							capt = cfall[ch];
							if (crise[ch]) begin
								next_s.cnt = 16'h0000;
							end
						end
						CAP_RSVD: capt = 1'b0;
					endcase
					if (capt) begin
						// a capture overwritten while its channel flag is still set in stat (not yet cleared) is the error case
						flg[S_ERR] = flg[S_ERR] | s.stat[S_CC + i];
						flg[S_CC + i] = 1'b1;
						next_s.cc[i] = s.cnt;
					end
				end
			end
		end
		if (s.awx.fault_en && |(ev & s.awx.fault_mask)) begin
			flg[S_FAULT] = 1'b1;
		end

		awon = |s.awx.dti_en || s.awx.pat_en;
		wgp = c.split ? {s.wgh, s.wg} : {4'h0, s.wg};
		for (int j = 0; j < PORT_W; j++) begin
			if (!s.ovr.en[j]) begin
				next_s.port[j] = s.ovr.port_val[j];
			end else if (!awon) begin
				next_s.port[j] = wgp[j];
			end else if (s.stat[S_FAULT]) begin
				next_s.port[j] = 1'b0;
			end else if (s.awx.pat_en) begin
				next_s.port[j] = s.ovr.pat[j] & (!s.awx.pat_wga | s.wg[0]);
			end else begin
				next_s.port[j] = (j % 2 == 1) ? s.hs[j / 2] : s.ls[j / 2];
			end
		end

		if (bus) begin
			unique case (I_WB_ADR)
				A_CTRL: rd = s.ctrl;
				A_PER: rd = {16'h0000, s.per_buf};
				A_CNT: rd = {16'h0000, s.cnt};
				A_STAT: rd = {24'h000000, s.stat};
				A_AWX: rd = s.awx;
				A_DT: rd = s.dt_buf;
				A_OVR: rd = {s.ovr.spare, s.ovr.port_val, s.pat_buf, s.ovr.en};
				A_HRF: rd = {20'h00000, s.hrf};
				default: rd = '0;
			endcase
			for (int i = 0; i < NUM_CC; i++) begin
				cadr = A_CC0 + CC_STEP * 8'(i);
				if (I_WB_ADR == cadr) begin
					rd = {16'h0000, c.cap_mode ? s.cc[i] : s.cc_buf[i]};
				end
			end
			next_s.rdat = rd;
			if (I_WB_WE) begin
				wd = wmerge(rd, I_WB_DAT, I_WB_SEL);
				unique case (I_WB_ADR)
					A_CTRL: begin
						next_s.ctrl = tcw_ctrl_type'(wd);
						next_s.ctrl.spare = 4'h0;
						next_s.ctrl.split = wd[9] & TYPE0;
					end
					A_PER: next_s.per_buf = wd[15:0];
					A_CNT: next_s.cnt = wd[15:0];
					A_STAT: next_s.stat = s.stat & ~(I_WB_DAT[7:0] & {8{I_WB_SEL[0]}});
					A_AWX: begin
						next_s.awx = tcw_awx_type'(wd);
						next_s.awx.spare = 20'h00000;
					end
					A_DT: next_s.dt_buf = tcw_dt_type'({16'h0000, wd[15:0]});
					A_OVR: begin
						// the live pattern only changes at an update or while the clock is off (CK_OFF), from the buffer
						next_s.ovr.en = wd[7:0];
						next_s.pat_buf = wd[15:8];
						next_s.ovr.port_val = wd[23:16];
					end
					A_HRF: next_s.hrf = wd[11:0];
					default: next_s.rdat = rd;
				endcase
				for (int i = 0; i < NUM_CC; i++) begin
					cadr = A_CC0 + CC_STEP * 8'(i);
					if (I_WB_ADR == cadr) begin
						next_s.cc_buf[i] = wd[15:0];
					end
				end
			end
		end

		// hardware sets are applied after the software clear so a same-cycle event survives
		next_s.stat = next_s.stat | flg;
		next_s.ev_ovf = flg[S_OVF];
		next_s.ev_err = flg[S_ERR];
		next_s.ev_hunf = flg[S_HUNF];
		next_s.ev_cc = flg[S_CC +: NCH];
	end

	assign O_WB_DAT = s.rdat;
	assign O_WB_ACK = s.ack;
	assign O_PORT = s.port;
	assign O_OVF_EV = s.ev_ovf;
	assign O_ERR_EV = s.ev_err;
	assign O_HUNF_EV = s.ev_hunf;
	assign O_CC_EV = s.ev_cc;
	assign O_FAULT = s.stat[S_FAULT];
endmodule
`default_nettype wire

// [hw/tcw_pkg.sv]
package tcw_pkg;
	localparam int ADR_W = 8;
	localparam int NCH = 4;
	localparam int PORT_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PER = 8'h04;
	localparam logic [7:0] A_CNT = 8'h08;
	localparam logic [7:0] A_CC0 = 8'h0C;
	localparam logic [7:0] CC_STEP = 8'h04;
	localparam logic [7:0] A_STAT = 8'h1C;
	localparam logic [7:0] A_AWX = 8'h20;
	localparam logic [7:0] A_DT = 8'h24;
	localparam logic [7:0] A_OVR = 8'h28;
	localparam logic [7:0] A_HRF = 8'h2C;
	localparam int S_OVF = 0;
	localparam int S_ERR = 1;
	localparam int S_CC = 2;
	localparam int S_HUNF = 6;
	localparam int S_FAULT = 7;
	localparam logic [1:0] NC_LAST = 2'h3;
	typedef enum logic [2:0] {CK_OFF = 3'h0, CK_D1 = 3'h1, CK_D2 = 3'h2, CK_D4 = 3'h3,
		CK_D8 = 3'h4, CK_D64 = 3'h5, CK_D256 = 3'h6, CK_EV = 3'h7} tcw_clk_type;
	localparam logic [7:0] DIV_MASK [8] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h07, 8'h3F, 8'hFF, 8'h00};
	typedef enum logic [1:0] {WG_NORMAL = 2'h0, WG_FREQ = 2'h1, WG_SINGLE = 2'h2, WG_DUAL = 2'h3} tcw_wgm_type;
	typedef enum logic [1:0] {CAP_INPUT = 2'h0, CAP_FREQ = 2'h1, CAP_PW = 2'h2, CAP_RSVD = 2'h3} tcw_cap_type;
	typedef enum logic [1:0] {HR_OFF = 2'h0, HR_X4 = 2'h1, HR_X8 = 2'h2, HR_RSVD = 2'h3} tcw_hr_type;
	typedef struct packed {
		logic [3:0] spare;
		logic [1:0] rst_ch;
		logic rst_en;
		logic nc_en;
		tcw_hr_type hires;
		logic [3:0] cc_en;
		logic qdec;
		logic [1:0] dir_ch;
		logic dir_ev;
		logic [1:0] cap_ch;
		tcw_cap_type cap_kind;
		logic split;
		logic cap_mode;
		logic down;
		tcw_wgm_type wgm;
		logic [1:0] clk_ch;
		tcw_clk_type clksel;
	} tcw_ctrl_type;
	typedef struct packed {
		logic [19:0] spare;
		logic [3:0] fault_mask;
		logic fault_en;
		logic pat_wga;
		logic halt_dt;
		logic pat_en;
		logic [3:0] dti_en;
	} tcw_awx_type;
	typedef struct packed {
		logic [15:0] spare;
		logic [7:0] hs;
		logic [7:0] ls;
	} tcw_dt_type;
	typedef struct packed {
		logic [7:0] spare;
		logic [7:0] port_val;
		logic [7:0] pat;
		logic [7:0] en;
	} tcw_ovr_type;
	typedef struct packed {
		logic [NCH-1:0] sync1;
		logic [NCH-1:0] sync2;
		logic [NCH-1:0] evd;
		logic [NCH-1:0] evf;
		logic [NCH-1:0][1:0] nc;
		logic [NCH-1:0] capl;
		logic [1:0] qprev;
		logic [7:0] pre;
		logic [15:0] cnt;
		logic dual_dn;
		logic ftog;
		logic [2:0] phase;
		logic [15:0] per;
		logic [15:0] per_buf;
		logic [NCH-1:0][15:0] cc;
		logic [NCH-1:0][15:0] cc_buf;
		tcw_ctrl_type ctrl;
		tcw_awx_type awx;
		tcw_dt_type dt;
		tcw_dt_type dt_buf;
		tcw_ovr_type ovr;
		logic [7:0] pat_buf;
		logic [NCH-1:0][2:0] hrf;
		logic [7:0] stat;
		logic [NCH-1:0] wg;
		logic [NCH-1:0] wgh;
		logic [NCH-1:0] wgd;
		logic [NCH-1:0][7:0] dtc;
		logic [NCH-1:0] ls;
		logic [NCH-1:0] hs;
		logic [PORT_W-1:0] port;
		logic ev_ovf;
		logic ev_err;
		logic ev_hunf;
		logic [NCH-1:0] ev_cc;
		logic [31:0] rdat;
		logic ack;
	} tcw_state_type;
	localparam tcw_state_type ST_RESET = '0;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = dat[b*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

// [hw/tcw_unused_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [verification/tcw_timer_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module tcw_timer_chk import tcw_pkg::*; #(
	parameter int NUM_CC = 4
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [ADR_W-1:0] I_WB_ADR,
	input wire logic [31:0] I_WB_DAT,
	input wire logic O_WB_ACK,
	input wire logic [PORT_W-1:0] O_PORT,
	input wire logic O_ERR_EV,
	input wire logic O_HUNF_EV,
	input wire logic [NCH-1:0] O_CC_EV,
	input wire logic O_FAULT
);
	logic wr;
	logic spl;
	logic capm;
	logic fen;
	logic [7:0] ovr_en;
	// shadow of the few control bits the properties depend on; bench always writes all lanes
	assign wr = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK;
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			spl <= 1'b0;
			capm <= 1'b0;
			fen <= 1'b0;
			ovr_en <= 8'h00;
		end else if (wr && I_WB_ADR == A_CTRL) begin
			spl <= I_WB_DAT[9];
			capm <= I_WB_DAT[8];
		end else if (wr && I_WB_ADR == A_AWX) begin
			fen <= I_WB_DAT[7];
		end else if (wr && I_WB_ADR == A_OVR) begin
			ovr_en <= I_WB_DAT[7:0];
		end
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	sequence s_req;
		I_WB_CYC && I_WB_STB && !O_WB_ACK;
	endsequence
	sequence s_ack;
		O_WB_ACK ##1 !O_WB_ACK;
	endsequence
	a_ack_latency: assert property (s_req |=> s_ack) else $error("ack not a single pulse after request");
	a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB)) else $error("ack without request");
	a_reset_quiet: assert property ($fell(I_RST) |-> !O_WB_ACK && O_PORT == '0 && !O_FAULT) else $error("outputs active after reset");
	a_cc_count: assert property ((O_CC_EV >> NUM_CC) == '0) else $error("event on missing channel");
	a_split_hunf: assert property (!spl && !$past(spl) && !$past(spl, 2) |-> !O_HUNF_EV) else $error("high underflow outside split");
	a_err_capture: assert property (!capm && !$past(capm) && !$past(capm, 2) |-> !O_ERR_EV) else $error("error event in compare mode");
	a_fault_pins: assert property (O_FAULT [*2] |-> (O_PORT & ovr_en) == '0) else $error("pins driven during fault");
	a_fault_enable: assert property ($rose(O_FAULT) |-> fen) else $error("fault while protection off");
endmodule
bind tcw_timer tcw_timer_chk #(.NUM_CC(NUM_CC)) u_tcw_timer_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
	.I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_DAT(I_WB_DAT),
	.O_WB_ACK(O_WB_ACK), .O_PORT(O_PORT), .O_ERR_EV(O_ERR_EV), .O_HUNF_EV(O_HUNF_EV), .O_CC_EV(O_CC_EV),
	.O_FAULT(O_FAULT));
`default_nettype wire

// [verification/tcw_drv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcw_drv_model import tcw_pkg::*; (
	input wire logic i_clk,
	input wire logic [PORT_W-1:0] i_pins,
	input wire logic i_trip,
	output logic o_fault,
	output var int o_shoot
);
	int cnt = 0;
	// desaturation sense of the switch stage comes back as a fault event
	assign o_fault = i_trip;
	assign o_shoot = cnt;
	always @(posedge i_clk) begin
		for (int i = 0; i < PORT_W / 2; i++) begin
			if (i_pins[2*i] && i_pins[2*i+1]) begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/timer_counter_waveform_ext_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module timer_counter_waveform_ext_tb import tcw_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic trip = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [2:0] ev = 3'h0;
	logic [31:0] rdat, rv, x;
	logic ack, ovf, err, hunf, fault, drv_ev;
	logic [NCH-1:0] ccev;
	logic [PORT_W-1:0] port;
	int shoot, s0, n;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 31630;
	int divs [7] = '{0, 1, 2, 4, 8, 64, 256};
	always #50 clk = ~clk;
	tcw_timer #(.TYPE0(1'b1), .NUM_CC(4)) u_tcw_timer (.I_REF_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
		.I_EVENT({ev, drv_ev}), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_PORT(port), .O_OVF_EV(ovf),
		.O_ERR_EV(err), .O_HUNF_EV(hunf), .O_CC_EV(ccev), .O_FAULT(fault));
	tcw_drv_model u_tcw_drv_model (.i_clk(clk), .i_pins(port), .i_trip(trip), .o_fault(drv_ev), .o_shoot(shoot));
	function automatic int per_cycles(input int per, input int k);
		return (per + 1) * divs[k];
	endfunction
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		k = 0;
		// ack and read data are taken at the edge that samples ack high; only then does the request drop
		do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
		if (k >= 50) fail_count++;
		rv = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// counts cycles up to the next pulse; bounded so a dead counter cannot hang the run
	task wait_sig(input int which, output int cnt);
		logic hit;
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
			hit = (which == 0) ? ovf : (which == 1) ? hunf : (which == 2) ? fault : ccev[0];
		end while (hit !== 1'b1 && cnt < 3000);
	endtask
	task measure(input int which, input int exp, input string what);
		wait_sig(which, n);
		wait_sig(which, n);
		chk(what, n, exp);
	endtask
	task run(input logic [31:0] per, input logic [31:0] ctrl);
		wb(1'b1, A_CTRL, 32'h0);
		wb(1'b1, A_PER, per);
		wb(1'b1, A_CNT, 32'h0);
		wb(1'b1, A_CTRL, ctrl);
	endtask
	initial begin
		#3000000;
		fail_count++;
		$display("watchdog expired");
		final_report;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, A_CTRL, 32'h0);
		chk("ctrl reset", rv, 32'h0);
		wb(1'b0, A_STAT, 32'h0);
		chk("stat reset", rv, 32'h0);
		wb(1'b1, 8'hF0, 32'hFFFFFFFF);
		wb(1'b0, 8'hF0, 32'h0);
		chk("unmapped", rv, 32'h0);
		$display("test reset done");
		for (int i = 0; i < NCH; i++) begin
			x = $random(seed);
			wb(1'b1, 8'(A_CC0 + CC_STEP * i), x);
			wb(1'b0, 8'(A_CC0 + CC_STEP * i), 32'h0);
			chk("channel buffer", rv, x & 32'hFFFF);
		end
		x = $random(seed);
		wb(1'b1, A_DT, x);
		wb(1'b0, A_DT, 32'h0);
		chk("dead time buffer", rv, x & 32'hFFFF);
		$display("test registers done");
		for (int k = 1; k < 7; k++) begin
			run(32'h3, 32'(k));
			measure(0, per_cycles(3, k), "prescaled period");
		end
		run(32'h5, 32'h81);
		measure(0, per_cycles(5, 1), "down period");
		x = $random(seed) & 32'h3F;
		run(x, 32'h1);
		measure(0, per_cycles(int'(x), 1), "random period");
		run(32'h9, 32'h1);
		measure(0, 10, "old period");
		wb(1'b1, A_PER, 32'h3);
		measure(0, 4, "buffered period");
		wb(1'b0, A_STAT, 32'h0);
		chk("overflow flag", rv[S_OVF], 32'h1);
		run(32'h4, 32'h61);
		measure(0, 8, "dual period");
		run(32'h9, 32'h40001);
		wb(1'b1, A_CC0, 32'h3);
		measure(3, 10, "compare event period");
		run(32'h2, 32'h0F);
		repeat (4) begin
			@(posedge clk);
			ev[0] <= 1'b1;
			repeat (2) @(posedge clk);
			ev[0] <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		wb(1'b0, A_CNT, 32'h0);
		chk("event count", rv, 32'h1);
		$display("test counter done");
		run(32'h0305, 32'h601);
		measure(0, 6, "low underflow");
		measure(1, 4, "high underflow");
		wb(1'b0, A_CTRL, 32'h0);
		chk("split bit", rv[9], 32'h1);
		$display("test split done");
		run(32'd20, 32'h0);
		wb(1'b1, A_CC0, 32'd8);
		wb(1'b1, A_DT, 32'h0202);
		wb(1'b1, A_OVR, 32'hFF);
		wb(1'b1, A_AWX, 32'h18F);
		s0 = shoot;
		wb(1'b1, A_CTRL, 32'h40041);
		repeat (200) @(posedge clk);
		chk("shoot through", shoot - s0, 32'h0);
		trip <= 1'b1;
		wait_sig(2, n);
		chk("fault raised", fault, 32'h1);
		repeat (3) @(negedge clk);
		chk("pins off", port, 32'h0);
		@(posedge clk);
		trip <= 1'b0;
		repeat (6) @(posedge clk);
		wb(1'b1, A_STAT, 32'h80);
		@(negedge clk);
		chk("fault cleared", fault, 32'h0);
		$display("test fault done");
		final_report;
	end
endmodule
`default_nettype wire
